/* hdl/cycle_phase_defines.vh */
// Phase codes, timing figures and widths for the cycle phase sequencer
`ifndef CYCLE_PHASE_DEFINES_VH
`define CYCLE_PHASE_DEFINES_VH
`define CLOCK_PERIOD_NS     8
`define MIN_CYCLE_NS        250
`define MIN_CYCLE_CLOCKS    ((`MIN_CYCLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define MIN_QUARTER_CLOCKS  ((`MIN_CYCLE_CLOCKS + 3) / 4)
`define QUARTER_CLOCKS      8'd8
`define QCOUNT_WIDTH        8
`define PHASE_Q1            2'h0
`define PHASE_Q2            2'h1
`define PHASE_Q3            2'h2
`define PHASE_Q4            2'h3
`define ADDR_WIDTH          13
`define INSTR_WIDTH         16
`define DATA_WIDTH          8
`define ADDR_RESET          13'h0000
`endif

/* hdl/quarter_phase_gen.v */
// Quarter-cycle phase generator driven from the device clock
`timescale 1ns/100ps
`include "cycle_phase_defines.vh"
module quarter_phase_gen (
  input  wire       i_clock,
  input  wire       i_ce,
  output reg  [1:0] o_phase,
  output reg        o_phase_start
);
  reg [`QCOUNT_WIDTH-1:0] count_q;

  // Free-running quarter counter; reset deliberately leaves it alone
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (count_q >= `QUARTER_CLOCKS - 8'd1 || count_q == 8'hFF) begin
        count_q       <= 8'h00;
        o_phase       <= o_phase + 2'h1;
        o_phase_start <= 1'b1;
      end else begin
        count_q       <= count_q + 8'h01;
        o_phase_start <= 1'b0;
      end
    end
  end

  // Power-up values so simulation starts in a known phase
  initial begin
    count_q       = 8'h00;
    o_phase       = `PHASE_Q4;
    o_phase_start = 1'b0;
  end
endmodule

/* hdl/pin_sync3.v */
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/100ps
`include "cycle_phase_defines.vh"
module pin_sync3 (
  input  wire i_clock,
  input  wire i_ce,
  input  wire i_pin,
  output reg  o_level
);
  reg meta_q;
  reg s2_q;
  reg s3_q;

  // Level changes only once stages two and three agree
  always @(posedge i_clock) begin
    if (i_ce) begin
      meta_q <= i_pin;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

  initial begin
    meta_q  = 1'b1;
    s2_q    = 1'b1;
    s3_q    = 1'b1;
    o_level = 1'b1;
  end
endmodule

/* hdl/cycle_phase_bus_sequencer.v */
// Instruction-cycle phase sequencer: strobes, bank enables, bus control
`timescale 1ns/100ps
`include "cycle_phase_defines.vh"
module cycle_phase_bus_sequencer (
  input  wire                    i_clock,
  input  wire                    i_resetn,
  input  wire                    i_ce,
  input  wire                    i_halt_n,
  input  wire [`INSTR_WIDTH-1:0] i_instruction,
  input  wire [`DATA_WIDTH-1:0]  i_io_bus_in,
  input  wire                    i_select_cmd,
  input  wire                    i_write_cmd,
  input  wire                    i_left_bank_next,
  input  wire                    i_right_bank_next,
  input  wire                    i_bank_change_in,
  input  wire [`ADDR_WIDTH-1:0]  i_next_address,
  input  wire [`DATA_WIDTH-1:0]  i_io_bus_data,
  output reg                     o_select_command_strobe,
  output reg                     o_write_command_strobe,
  output reg                     o_left_bank_enable_n,
  output reg                     o_right_bank_enable_n,
  output reg  [`ADDR_WIDTH-1:0]  o_program_address_out,
  output reg  [`ADDR_WIDTH-1:0]  o_program_counter,
  output reg  [`INSTR_WIDTH-1:0] o_instruction_latched,
  output reg  [`DATA_WIDTH-1:0]  o_io_bus_latched,
  output reg  [`DATA_WIDTH-1:0]  o_io_bus_out,
  output reg                     o_io_bus_oe,
  output reg                     o_cycle_end,
  output reg                     o_halt_cycle,
  output reg                     o_execute_enable,
  output reg  [1:0]              o_phase
);
  wire [1:0] phase;
  wire       phase_start;
  wire       halt_level_n;
  reg        halt_seen_q;
  reg        reset_seen_q;
  reg        post_reset_q;
  reg        halt_d;

  // Quarter phases come from the device clock (counter wraps at QUARTER_CLOCKS - 1)
  quarter_phase_gen u_phase (
    .i_clock       (i_clock),
    .i_ce          (i_ce),
    .o_phase       (phase),
    .o_phase_start (phase_start)
  );

  // The halt pin is asynchronous to our clock
  pin_sync3 u_halt_sync (
    .i_clock (i_clock),
    .i_ce    (i_ce),
    .i_pin   (i_halt_n),
    .o_level (halt_level_n)
  );

  // Halt decision taken at end of quarter one: low at any sample in it means halt
  always @* begin
    halt_d = halt_seen_q | ~halt_level_n;
  end

  // Halt sampling and reset bookkeeping
  always @(posedge i_clock) begin
    if (i_ce) begin
      o_phase <= phase;
      if (!i_resetn) begin
        reset_seen_q <= 1'b1;
      end else if (reset_seen_q && phase_start) begin
        reset_seen_q <= 1'b0;
        post_reset_q <= 1'b1;
      end else if (post_reset_q && phase_start && phase == `PHASE_Q1) begin
        post_reset_q <= 1'b0;
      end
      if (phase == `PHASE_Q1) begin
        if (phase_start) begin
          halt_seen_q <= ~halt_level_n;
        end else begin
          halt_seen_q <= halt_d;
        end
      end
      if (phase_start && phase == `PHASE_Q2) begin
        o_halt_cycle <= halt_seen_q;
      end else if (phase_start && phase == `PHASE_Q1 && halt_level_n) begin
        o_halt_cycle <= 1'b0;
      end
    end
  end

  // Cycle-end pulse: quarter four only, gated by reset and by the first quarter start after release
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (!i_resetn) begin
        o_cycle_end <= 1'b0;
      end else if (post_reset_q && phase_start && phase == `PHASE_Q4) begin
        o_cycle_end <= 1'b1;
      end else if (phase_start) begin
        o_cycle_end <= (phase == `PHASE_Q4) && !reset_seen_q;
      end
    end
  end

  // Strobes move only at quarter one or three starts or on reset, and never overlap
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (!i_resetn) begin
        o_select_command_strobe <= 1'b0;
        o_write_command_strobe  <= 1'b0;
      end else if (phase_start && (phase == `PHASE_Q1 || phase == `PHASE_Q3)) begin
        // Through the first quarter-one start following the first quarter start after release nothing may be commanded
        if (o_halt_cycle || halt_d || post_reset_q || reset_seen_q) begin
          o_select_command_strobe <= 1'b0;
          o_write_command_strobe  <= 1'b0;
        end else begin
          o_select_command_strobe <= i_select_cmd;
          o_write_command_strobe  <= i_write_cmd & ~i_select_cmd;
        end
      end
    end
  end

  // Bank enables: left and right each follow their own next-bank input
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (i_resetn && !o_halt_cycle) begin
        if (phase == `PHASE_Q1 && i_bank_change_in) begin
          o_left_bank_enable_n  <= ~i_left_bank_next;
          o_right_bank_enable_n <= ~i_right_bank_next;
        end else if (phase == `PHASE_Q3 && !i_bank_change_in) begin
          o_left_bank_enable_n  <= ~i_left_bank_next;
          o_right_bank_enable_n <= ~i_right_bank_next;
        end
      end
      // Held, not driven, during reset; receivers must ignore them
    end
  end

  // Input latches: instruction in quarter one, I/O bus in one and two
  always @(posedge i_clock) begin
    if (i_ce && i_resetn && !o_halt_cycle) begin
      if (phase == `PHASE_Q1) begin
        o_instruction_latched <= i_instruction;
      end
      if (phase == `PHASE_Q1 || phase == `PHASE_Q2) begin
        o_io_bus_latched <= i_io_bus_in;
      end
    end
  end

  // Program counter and address latch; reset clears both and holds them
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (!i_resetn) begin
        o_program_counter     <= `ADDR_RESET;
        o_program_address_out <= `ADDR_RESET;
      end else if (!o_halt_cycle && !post_reset_q && !reset_seen_q) begin
        if (phase == `PHASE_Q3) begin
          o_program_address_out <= i_next_address;
        end
        if (phase_start && phase == `PHASE_Q4) begin
          o_program_counter <= i_next_address;
        end
      end
    end
  end

  // Bus drivers enabled through quarters three and four only
  always @(posedge i_clock) begin
    if (i_ce) begin
      if (!i_resetn) begin
        o_io_bus_oe <= 1'b0;
      end else if (o_halt_cycle || post_reset_q || reset_seen_q) begin
        // A release in mid-quarter must not switch drivers on halfway through
        o_io_bus_oe <= 1'b0;
      end else begin
        o_io_bus_oe <= (phase == `PHASE_Q3 || phase == `PHASE_Q4);
      end
      o_io_bus_out     <= i_io_bus_data;
      o_execute_enable <= i_resetn && !o_halt_cycle && !post_reset_q && !reset_seen_q;
    end
  end

  // Power-up state; reset itself only affects the documented registers
  initial begin
    halt_seen_q             = 1'b0;
    reset_seen_q            = 1'b1;
    post_reset_q            = 1'b0;
    o_select_command_strobe = 1'b0;
    o_write_command_strobe  = 1'b0;
    o_left_bank_enable_n    = 1'b1;
    o_right_bank_enable_n   = 1'b1;
    o_program_address_out   = `ADDR_RESET;
    o_program_counter       = `ADDR_RESET;
    o_instruction_latched   = 16'h0000;
    o_io_bus_latched        = 8'h00;
    o_io_bus_out            = 8'h00;
    o_io_bus_oe             = 1'b0;
    o_cycle_end             = 1'b0;
    o_halt_cycle            = 1'b0;
    o_execute_enable        = 1'b0;
    o_phase                 = `PHASE_Q4;
  end
endmodule

/* sim/cycle_phase_bus_sequencer_sva.sv */
// Port-level checker for the cycle phase bus sequencer
`timescale 1ns/100ps
`include "cycle_phase_defines.vh"
module cycle_phase_bus_sequencer_sva (
  input wire logic                   i_clock,
  input wire logic                   i_resetn,
  input wire logic                   o_select_command_strobe,
  input wire logic                   o_write_command_strobe,
  input wire logic                   o_io_bus_oe,
  input wire logic                   o_cycle_end,
  input wire logic                   o_halt_cycle,
  input wire logic [`ADDR_WIDTH-1:0] o_program_address_out,
  input wire logic [`ADDR_WIDTH-1:0] o_program_counter,
  input wire logic [1:0]             o_phase
);
  // Short aliases keep all properties but a_reset_clear and a_halt_hold on one line
  wire             sc = o_select_command_strobe;
  wire             wc = o_write_command_strobe;
  wire             oe = o_io_bus_oe;
  wire [1:0]       ph = o_phase;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Pulse is one full quarter, then drops
  sequence s_end_pulse; o_cycle_end[*8] ##1 !o_cycle_end; endsequence
  // No pulse inside the first quarter after reset release
  sequence s_quiet_quarter; !o_cycle_end[*8]; endsequence
  a_strobe_excl: assert property (!(sc && wc))
    else $error("select and write strobes both high");
  a_strobe_phase: assert property ($changed({sc, wc}) |-> ph == `PHASE_Q1 || ph == `PHASE_Q3)
    else $error("strobe changed outside quarters one and three");
  a_end_len: assert property ($rose(o_cycle_end) |-> s_end_pulse)
    else $error("cycle end pulse not one quarter long");
  a_reset_quiet: assert property ($rose(i_resetn) |-> s_quiet_quarter)
    else $error("cycle end pulse too soon after reset");
  a_reset_clear: assert property ($rose(i_resetn) |-> o_program_address_out == 13'h0000 &&
    o_program_counter == 13'h0000 && !sc && !wc && !oe)
    else $error("reset left address, counter, strobes or drivers active");
  a_oe_start: assert property ($rose(oe) |-> ph == `PHASE_Q3)
    else $error("bus drivers turned on outside quarter three");
  a_oe_stop: assert property ($fell(oe) |-> ph == `PHASE_Q1)
    else $error("bus drivers turned off before quarter four ended");
  a_halt_quiet: assert property (o_halt_cycle && ph == `PHASE_Q4 |-> !sc && !wc && !oe)
    else $error("halt cycle with strobe or driver active");
  a_halt_hold: assert property (o_halt_cycle && $past(o_halt_cycle) |->
    $stable(o_program_address_out) && $stable(o_program_counter))
    else $error("address or counter moved in halt");
  a_halt_resume: assert property ($fell(o_halt_cycle) |-> ph == `PHASE_Q1)
    else $error("halt ended outside quarter one");
  a_phase_step: assert property ($changed(ph) |-> ph == $past(ph) + 2'h1)
    else $error("quarter phase skipped");
  a_phase_len: assert property ($changed(ph) |=> $stable(ph)[*7])
    else $error("quarter shorter than eight clocks");
endmodule
bind cycle_phase_bus_sequencer cycle_phase_bus_sequencer_sva u_sva (.i_clock, .i_resetn,
  .o_select_command_strobe, .o_write_command_strobe, .o_io_bus_oe, .o_cycle_end,
  .o_halt_cycle, .o_program_address_out, .o_program_counter, .o_phase);

/* sim/prog_io_model.sv */
// Program storage and bank-selected I/O port model on the far side
`timescale 1ns/100ps
module prog_io_model (
  input  wire logic        i_clock,
  input  wire logic [12:0] i_address,
  input  wire logic        i_left_n,
  input  wire logic        i_right_n,
  output logic      [15:0] o_instruction,
  output logic      [7:0]  o_bus
);
  logic [7:0] noise_q = 8'h00;
  // A floating bus must not look like held data, so it churns every clock
  always @(posedge i_clock) noise_q <= noise_q + 8'h5B;
  // Storage word is a fixed function of the address
  assign o_instruction = {3'h5, i_address};
  // Only one selected bank answers; both or none leaves the bus floating
  always_comb begin
    if (!i_left_n && i_right_n) o_bus = 8'hA5;
    else if (i_left_n && !i_right_n) o_bus = 8'h3C;
    else o_bus = noise_q;
  end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the cycle phase bus sequencer
`timescale 1ns/100ps
`include "cycle_phase_defines.vh"
module testbench;
  logic        i_clock = 1'b0;
  logic        rstn = 1'b0;
  logic        halt_n = 1'b1;
  logic        sel = 1'b0, wr = 1'b0, lb = 1'b0, rb = 1'b0, bchg = 1'b1;
  logic [12:0] nxt = 13'h0000, adr, pc, hold_a;
  logic [7:0]  dout = 8'h00, bus, iol, ioo;
  logic [15:0] ins, ins_q;
  logic [1:0]  ph;
  logic        sc, wc, lbn, rbn, oe, cend, hc, ex;
  int          n_fail = 0;
  int          cmp_count = 0;
  prog_io_model model (.i_clock(i_clock), .i_address(adr), .i_left_n(lbn), .i_right_n(rbn),
    .o_instruction(ins), .o_bus(bus));
  cycle_phase_bus_sequencer uut (.i_clock(i_clock), .i_resetn(rstn), .i_ce(1'b1),
    .i_halt_n(halt_n), .i_instruction(ins), .i_io_bus_in(bus), .i_select_cmd(sel),
    .i_write_cmd(wr), .i_left_bank_next(lb), .i_right_bank_next(rb), .i_bank_change_in(bchg),
    .i_next_address(nxt), .i_io_bus_data(dout), .o_select_command_strobe(sc),
    .o_write_command_strobe(wc), .o_left_bank_enable_n(lbn), .o_right_bank_enable_n(rbn),
    .o_program_address_out(adr), .o_program_counter(pc), .o_instruction_latched(ins_q),
    .o_io_bus_latched(iol), .o_io_bus_out(ioo), .o_io_bus_oe(oe), .o_cycle_end(cend),
    .o_halt_cycle(hc), .o_execute_enable(ex), .o_phase(ph));
  // Clock and watchdog; the run needs about 700 clocks
  initial forever #4 i_clock = ~i_clock;
  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    finish_test();
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Returns at the first falling edge inside quarter p
  task automatic at_start(input logic [1:0] p);
    int n;
    for (n = 0; n < 40 && ph === p; n++) @(negedge i_clock);
    for (n = 0; n < 40 && ph !== p; n++) @(negedge i_clock);
  endtask
  task automatic t_strobes;
    logic [1:0] pat [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    foreach (pat[i]) begin
      at_start(`PHASE_Q4);
      {sel, wr} = pat[i];
      at_start(`PHASE_Q2);
      if (pat[i] != 2'b11) check(16'({sc, wc}), 16'(pat[i]));
      else check(16'(sc & wc), 16'h0000);
    end
    $display("strobe test finished");
  endtask
  task automatic t_banks;
    at_start(`PHASE_Q4);
    {lb, rb} = 2'b10;
    at_start(`PHASE_Q2);
    check(16'({lbn, rbn}), 16'h0001);
    at_start(`PHASE_Q3);
    check(16'(iol), 16'h00A5);
    at_start(`PHASE_Q4);
    {bchg, lb, rb} = 3'b001;
    at_start(`PHASE_Q2);
    check(16'({lbn, rbn}), 16'h0001);
    at_start(`PHASE_Q4);
    check(16'({lbn, rbn}), 16'h0002);
    at_start(`PHASE_Q3);
    check(16'(iol), 16'h003C);
    bchg = 1'b1;
    $display("bank test finished");
  endtask
  task automatic t_addr;
    at_start(`PHASE_Q1);
    hold_a = adr;
    nxt = 13'h1ABC;
    at_start(`PHASE_Q2);
    check(16'(adr), 16'(hold_a));
    at_start(`PHASE_Q4);
    check(16'(adr), 16'h1ABC);
    at_start(`PHASE_Q2);
    check(16'(pc), 16'h1ABC);
    check(ins_q, 16'hBABC);
    $display("address test finished");
  endtask
  task automatic t_bus;
    at_start(`PHASE_Q1);
    dout = 8'h6E;
    at_start(`PHASE_Q2);
    check(16'(oe), 16'h0000);
    at_start(`PHASE_Q4);
    check(16'({oe, ioo}), 16'h016E);
    $display("bus test finished");
  endtask
  task automatic t_halt;
    at_start(`PHASE_Q4);
    hold_a = adr;
    {halt_n, sel, wr} = 3'b010;
    nxt = 13'h0F0F;
    at_start(`PHASE_Q3);
    check(16'(hc), 16'h0001);
    at_start(`PHASE_Q4);
    check(16'({sc, wc, oe, cend}), 16'h0001);
    check(16'(ex), 16'h0000);
    check(16'(adr), 16'(hold_a));
    at_start(`PHASE_Q3);
    check(16'(adr), 16'(hold_a));
    at_start(`PHASE_Q4);
    halt_n = 1'b1;
    at_start(`PHASE_Q2);
    check(16'(hc), 16'h0000);
    at_start(`PHASE_Q4);
    check(16'({sc, adr}), 16'h2F0F);
    check(16'(ex), 16'h0001);
    $display("halt test finished");
  endtask
  task automatic t_reset;
    int n;
    int w;
    at_start(`PHASE_Q4);
    rstn = 1'b0;
    repeat (33) @(negedge i_clock);
    check(16'({sc, wc, oe, cend}), 16'h0000);
    check(16'(adr | pc), 16'h0000);
    rstn = 1'b1;
    for (n = 0; n < 80 && cend !== 1'b1; n++) @(negedge i_clock);
    for (w = 0; w < 40 && cend === 1'b1; w++) @(negedge i_clock);
    check(16'(n >= 8), 16'h0001);
    check(16'(w), 16'h0008);
    $display("reset test finished");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Power-up reset, then the scenarios in turn
  initial begin
    repeat (4) @(negedge i_clock);
    rstn = 1'b1;
    repeat (70) @(negedge i_clock);
    t_strobes();
    t_banks();
    t_addr();
    t_bus();
    t_halt();
    t_reset();
    finish_test();
  end
endmodule
